//--- rtl/clsc_pkg.sv
/*
  constants, register map and state encoding for the closed-loop speed controller.
  assumes a 20 MHz pclk and an APB slave with 32-bit data, one register per aligned word.
*/
package clsc_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam int CLK_PERIOD_NS = 50;
  // bridge period step: one period unit of the 5-bit period select
  localparam int BRIDGE_STEP_NS = 1000;
  localparam int BRIDGE_STEP_CYCLES = BRIDGE_STEP_NS / CLK_PERIOD_NS;
  // speed gate of 10/6 s: commutation count over it equals electrical freq in 0.1 Hz
  localparam int SPEED_GATE_CYCLES = CLK_HZ * 10 / 6;
  localparam int MAX_ELECTRICAL_FREQ_EXP_BASE = 8;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h04;
  localparam logic [7:0] ADDR_DEMAND = 8'h08;
  localparam logic [7:0] ADDR_START = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_SPEED = 8'h14;

  // control bit positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_BRAKE_BIT = 1;
  localparam int CTRL_RESTART_BIT = 2;
  localparam int CTRL_SERIAL_BIT = 3;
  // configuration field positions
  localparam int CFG_SMX_LSB = 0;
  localparam int CFG_PERIOD_LSB = 8;
  localparam int CFG_PGAIN_LSB = 16;
  localparam int CFG_IGAIN_LSB = 20;
  localparam int START_SPEED_LSB = 0;
  localparam int START_DUTY_LSB = 16;

  // reset values
  localparam logic [3:0] CTRL_RESET = 4'h3;
  localparam logic [2:0] SMX_RESET = 3'h7;
  localparam logic [4:0] PERIOD_RESET = 5'h13;
  localparam logic [2:0] PGAIN_RESET = 3'h3;
  localparam logic [2:0] IGAIN_RESET = 3'h2;
  localparam logic [15:0] START_SPEED_RESET = 16'h0064;
  localparam logic [7:0] START_DUTY_RESET = 8'h40;

  // duty thresholds on an 8-bit scale, fault pattern and start counts, PI saturation limits
  localparam logic [7:0] DUTY_10PCT = 8'h19;
  localparam logic [7:0] DUTY_25PCT = 8'h40;
  localparam logic [7:0] DUTY_FULL = 8'hFF;
  localparam logic [2:0] FAULT_HALF = 3'h3;
  localparam logic [2:0] FAULT_LAST = 3'h5;
  localparam logic [1:0] FAULT_REPEATS = 2'h2;
  localparam logic [1:0] START_COMMS = 2'h2;
  localparam logic signed [25:0] DUTY_MAX = 26'sh000_00FF;
  localparam logic signed [25:0] INTEG_MAX = 26'sh000_FF00;

  typedef enum logic [2:0] {
    ST_BRAKE = 3'b000,
    ST_COAST = 3'b001,
    ST_START = 3'b010,
    ST_RUN = 3'b011,
    ST_DECAY = 3'b100,
    ST_LOS = 3'b101
  } clsc_state_t;
endpackage

//--- rtl/clsc_speed_ctrl.sv
/*
  closed-loop speed control: input duty measurement, state sequencing, PI loop,
  bridge PWM with fixed off-time current limit, loss-of-sync fault pattern, APB registers.
  assumes pwm_in, current_limit_in and the commutation status inputs are synchronous to pclk.
*/
// Our own choices: the placing of the registers and the APB slave port.
// Overview of operation
// - max frequency in 0.1 Hz units is 2 to the (select plus 8), minus one.
// - demand is duty times max frequency; PI corrects bridge duty against measured speed.
// - bridge PWM period comes from the 5-bit period select, not the input.
// - current trip forces off for one bridge period, released on period start.
// - proportional and integral gains come from separate 3-bit selects.
// - input inactive over two measured periods puts bridge off to decay.
// - one further inactive period applies brake when brake and run enabled.
// - after reset with brake and run enabled, brake holds until duty exceeds 10%.
// - brake enable clear means braking is never applied.
// - brake only after duty returns to zero; running motor above 0% never brakes.
// - after braking, non-running motor with duty 10% to 25% coasts.
// - duty above 25% starts the start sequence and lets the motor run.
// - during start demand is ignored until two commutations after hold time.
// - inactive timeout during start aborts it; brakes if brake and run enabled, else coasts.
// - too low speed or demand under quarter start speed switches bridge off.
// - loss of sync drives fault low three input periods, high three, repeating.
// - with run and auto-restart and duty over 25%, two patterns then restart.
// - without auto-restart fault stays until duty under 25% or run cleared.
// - demand and state come from the input duty or a serially written value.
// - if sensorless start fails, keep forcing commutation with repeated starts.
// - input duty is measured with 8-bit resolution.
module clsc_speed_ctrl
  import clsc_pkg::*;
#(
  parameter int GATE_CYCLES = SPEED_GATE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pwm_in,
  input wire logic current_limit_in,
  input wire logic comm_tick,
  input wire logic hold_done,
  input wire logic sync_lost,
  output logic bridge_pwm,
  output logic bridge_enable,
  output logic brake_out,
  output logic start_req,
  output logic fault_out_n
);
  function automatic logic signed [25:0] sat_range(input logic signed [25:0] v,
                                                   input logic signed [25:0] hi);
    if (v < 0) begin
      sat_range = '0;
    end else if (v > hi) begin
      sat_range = hi;
    end else begin
      sat_range = v;
    end
  endfunction

  // registers
  logic run_enable, brake_enable, auto_restart_enable, serial_sel;
  logic [2:0] max_speed_select, prop_gain_select, integ_gain_select;
  logic [4:0] bridge_period_select;
  logic [7:0] serial_duty_reg, start_duty_reg;
  logic [15:0] start_speed_reg;
  clsc_state_t state_reg, state_next;

  // input duty measurement
  logic pwm_d_reg;
  logic [23:0] per_cnt_reg, high_cnt_reg, low_cnt_reg, last_per_reg, last_high_reg;
  logic div_busy_reg;
  logic [2:0] div_bit_reg;
  logic [7:0] div_q_reg, meas_duty_reg;
  logic rise, to_decay, to_brake, stuck_high, zero_eff, brake_to_eff;
  logic [7:0] duty_eff, q_try;
  logic [25:0] per_x2, per_x3;

  assign rise = pwm_in & ~pwm_d_reg;
  assign per_x2 = {1'b0, last_per_reg, 1'b0};
  assign per_x3 = per_x2 + {2'b00, last_per_reg};
  assign to_decay = ~pwm_in && ({2'b00, low_cnt_reg} > per_x2);
  assign to_brake = ~pwm_in && ({2'b00, low_cnt_reg} > per_x3);
  assign stuck_high = pwm_in && ({2'b00, high_cnt_reg} > per_x2);
  assign duty_eff = serial_sel ? serial_duty_reg : (stuck_high ? DUTY_FULL : meas_duty_reg);
  assign zero_eff = serial_sel ? (serial_duty_reg == 8'h00) : to_decay;
  assign brake_to_eff = serial_sel ? (serial_duty_reg == 8'h00) : to_brake;
  assign q_try = div_q_reg | (8'h01 << div_bit_reg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_d_reg <= 1'b0;
      per_cnt_reg <= '0;
      high_cnt_reg <= '0;
      low_cnt_reg <= '0;
      last_per_reg <= '0;
      last_high_reg <= '0;
    end else begin
      pwm_d_reg <= pwm_in;
      per_cnt_reg <= rise ? 24'h00_0001 : per_cnt_reg + {23'h0, ~&per_cnt_reg};
      high_cnt_reg <= rise ? 24'h00_0001 : high_cnt_reg + {23'h0, pwm_in & ~&high_cnt_reg};
      low_cnt_reg <= pwm_in ? 24'h00_0000 : low_cnt_reg + {23'h0, ~&low_cnt_reg};
      if (rise) begin
        last_per_reg <= per_cnt_reg;
        last_high_reg <= high_cnt_reg;
      end
    end
  end

  // successive approximation of high*256/period, eight cycles after each rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_busy_reg <= 1'b0;
      div_bit_reg <= '0;
      div_q_reg <= '0;
      meas_duty_reg <= '0;
    end else if (rise) begin
      div_busy_reg <= 1'b1;
      div_bit_reg <= 3'h7;
      div_q_reg <= '0;
    end else if (div_busy_reg) begin
      if (32'(q_try) * 32'(last_per_reg) <= {last_high_reg, 8'h00}) begin
        div_q_reg <= q_try;
      end
      div_bit_reg <= div_bit_reg - 3'h1;
      if (div_bit_reg == 3'h0) begin
        div_busy_reg <= 1'b0;
      end
    end else begin
      // 8-bit result; a full-high period saturates to the top code
      meas_duty_reg <= (last_high_reg >= last_per_reg) ? DUTY_FULL : div_q_reg;
    end
  end

  // speed measurement in 0.1 Hz units and speed demand
  logic [25:0] gate_cnt_reg;
  logic [15:0] comm_acc_reg, speed_reg;
  logic gate_tick_reg;
  logic [14:0] max_electrical_freq_tenths;
  logic [22:0] demand_prod;
  logic [15:0] demand;

  assign max_electrical_freq_tenths = 15'((16'h0001 << (4'(max_speed_select) + 4'(MAX_ELECTRICAL_FREQ_EXP_BASE))) - 16'h0001);
  assign demand_prod = 23'(duty_eff) * 23'(max_electrical_freq_tenths);
  assign demand = {1'b0, demand_prod[22:8]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_cnt_reg <= '0;
      comm_acc_reg <= '0;
      speed_reg <= '0;
      gate_tick_reg <= 1'b0;
    end else begin
      gate_tick_reg <= 1'b0;
      if (gate_cnt_reg >= 26'(GATE_CYCLES - 1)) begin
        gate_cnt_reg <= '0;
        speed_reg <= comm_acc_reg + {15'h0, comm_tick};
        comm_acc_reg <= '0;
        gate_tick_reg <= 1'b1;
      end else begin
        gate_cnt_reg <= gate_cnt_reg + 26'h1;
        comm_acc_reg <= comm_acc_reg + {15'h0, comm_tick & ~&comm_acc_reg};
      end
    end
  end

  // PI loop, updated once per speed gate; integrator preloads start duty outside run
  logic signed [25:0] integ_reg, err, integ_sum, pi_sum;
  logic [7:0] pi_duty_reg;

  assign err = 26'(signed'({1'b0, demand})) - 26'(signed'({1'b0, speed_reg}));
  assign integ_sum = integ_reg + (err <<< integ_gain_select);
  assign pi_sum = (integ_reg >>> 8) + ((err <<< prop_gain_select) >>> 6);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      integ_reg <= '0;
      pi_duty_reg <= '0;
    end else if (state_reg != ST_RUN) begin
      integ_reg <= 26'({start_duty_reg, 8'h00});
      pi_duty_reg <= start_duty_reg;
    end else if (gate_tick_reg) begin
      integ_reg <= sat_range(integ_sum, INTEG_MAX);
      pi_duty_reg <= 8'(sat_range(pi_sum, DUTY_MAX));
    end
  end

  // start sequencing, fault pattern and state machine
  logic [1:0] start_comm_reg, fault_rep_reg;
  logic [2:0] fault_per_reg;
  logic start_pulse, run_cmd, low_demand;

  assign run_cmd = run_enable && !zero_eff && (duty_eff > DUTY_25PCT);
  assign low_demand = demand < {2'b00, start_speed_reg[15:2]};

  always_comb begin
    state_next = state_reg;
    start_pulse = 1'b0;
    case (state_reg)
      ST_BRAKE: begin
        if (!(brake_enable && run_enable)) begin
          state_next = ST_COAST;
        end else if (!zero_eff && duty_eff > DUTY_10PCT) begin
          state_next = ST_COAST;
        end
      end
      ST_COAST: begin
        if (run_cmd) begin
          state_next = ST_START;
          start_pulse = 1'b1;
        end else if (brake_to_eff && brake_enable && run_enable) begin
          state_next = ST_BRAKE;
        end
      end
      ST_START: begin
        if (zero_eff || !run_enable) begin
          state_next = (brake_enable && run_enable) ? ST_BRAKE : ST_COAST;
        end else if (sync_lost) begin
          start_pulse = 1'b1;
        end else if (start_comm_reg >= START_COMMS) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (zero_eff) begin
          state_next = ST_DECAY;
        end else if (!run_enable) begin
          state_next = ST_COAST;
        end else if (sync_lost || low_demand) begin
          state_next = ST_LOS;
        end
      end
      ST_DECAY: begin
        if (brake_to_eff) begin
          state_next = (brake_enable && run_enable) ? ST_BRAKE : ST_COAST;
        end else if (run_cmd) begin
          state_next = ST_START;
          start_pulse = 1'b1;
        end
      end
      ST_LOS: begin
        if (!run_enable || zero_eff) begin
          state_next = ST_COAST;
        end else if (!auto_restart_enable) begin
          if (duty_eff < DUTY_25PCT) begin
            state_next = ST_COAST;
          end
        end else if (duty_eff > DUTY_25PCT && fault_rep_reg >= FAULT_REPEATS) begin
          state_next = ST_START;
          start_pulse = 1'b1;
        end
      end
      default: begin
        state_next = ST_COAST;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_BRAKE;
    end else begin
      state_reg <= state_next;
    end
  end

  // commutations counted only once the start hold time has finished
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_comm_reg <= '0;
    end else if (state_reg != ST_START || start_pulse) begin
      start_comm_reg <= '0;
    end else if (hold_done && comm_tick && start_comm_reg < START_COMMS) begin
      start_comm_reg <= start_comm_reg + 2'h1;
    end
  end

  // pattern timed in input periods, and also in speed gates in serial mode: low for three, released for three
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_per_reg <= '0;
      fault_rep_reg <= '0;
    end else if (state_reg != ST_LOS) begin
      fault_per_reg <= '0;
      fault_rep_reg <= '0;
    end else if (rise || serial_sel && gate_tick_reg) begin
      if (fault_per_reg == FAULT_LAST) begin
        fault_per_reg <= '0;
        fault_rep_reg <= fault_rep_reg + {1'b0, fault_rep_reg < FAULT_REPEATS};
      end else begin
        fault_per_reg <= fault_per_reg + 3'h1;
      end
    end
  end

  // bridge PWM with fixed off-time current limit
  logic [9:0] br_per, br_cnt_reg, br_cmp, ilim_cnt_reg;
  logic [17:0] br_prod;
  logic [7:0] drive_duty;
  logic ilim_hold_reg, drive_on, period_start;

  assign br_per = 10'((16'(bridge_period_select) + 16'h1) * BRIDGE_STEP_CYCLES);
  assign drive_on = (state_reg == ST_START) || (state_reg == ST_RUN);
  // demand is not passed to the bridge while starting
  assign drive_duty = (state_reg == ST_RUN) ? pi_duty_reg : start_duty_reg;
  assign br_prod = 18'(drive_duty) * 18'(br_per);
  assign br_cmp = br_prod[17:8];
  assign period_start = (br_cnt_reg == 10'h000);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      br_cnt_reg <= '0;
    end else if (br_cnt_reg >= br_per - 10'h1) begin
      br_cnt_reg <= '0;
    end else begin
      br_cnt_reg <= br_cnt_reg + 10'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ilim_cnt_reg <= '0;
      ilim_hold_reg <= 1'b0;
    end else if (bridge_pwm && current_limit_in) begin
      ilim_cnt_reg <= br_per;
      ilim_hold_reg <= 1'b1;
    end else if (ilim_cnt_reg != 10'h000) begin
      ilim_cnt_reg <= ilim_cnt_reg - 10'h1;
    end else if (period_start) begin
      ilim_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bridge_pwm <= 1'b0;
      bridge_enable <= 1'b0;
      brake_out <= 1'b0;
      start_req <= 1'b0;
      fault_out_n <= 1'b1;
    end else begin
      bridge_pwm <= drive_on && !ilim_hold_reg && !(bridge_pwm && current_limit_in)
                    && (drive_duty == DUTY_FULL || br_cnt_reg < br_cmp);
      bridge_enable <= drive_on;
      brake_out <= (state_reg == ST_BRAKE) && brake_enable && run_enable;
      start_req <= start_pulse;
      fault_out_n <= !(state_reg == ST_LOS && state_next == ST_LOS
                       && fault_per_reg < FAULT_HALF);
    end
  end

  // APB slave: zero wait states, error on unmapped address
  logic setup;
  logic [31:0] rd_mux;
  logic mapped;

  assign setup = psel && !penable;
  always_comb begin
    rd_mux = '0;
    mapped = 1'b1;
    if (paddr == ADDR_CTRL) begin
      rd_mux = {28'h000_0000, serial_sel, auto_restart_enable, brake_enable, run_enable};
    end else if (paddr == ADDR_CFG) begin
      rd_mux = {9'h000, integ_gain_select, 1'b0, prop_gain_select, 3'h0,
                bridge_period_select, 5'h00, max_speed_select};
    end else if (paddr == ADDR_DEMAND) begin
      rd_mux = {24'h00_0000, serial_duty_reg};
    end else if (paddr == ADDR_START) begin
      rd_mux = {8'h00, start_duty_reg, start_speed_reg};
    end else if (paddr == ADDR_STATUS) begin
      rd_mux = {8'h00, pi_duty_reg, duty_eff, 4'h0, ~fault_out_n, state_reg};
    end else if (paddr == ADDR_SPEED) begin
      rd_mux = {demand, speed_reg};
    end else begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      prdata <= (setup && !pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {serial_sel, auto_restart_enable, brake_enable, run_enable} <= CTRL_RESET;
      max_speed_select <= SMX_RESET;
      bridge_period_select <= PERIOD_RESET;
      prop_gain_select <= PGAIN_RESET;
      integ_gain_select <= IGAIN_RESET;
      serial_duty_reg <= '0;
      start_speed_reg <= START_SPEED_RESET;
      start_duty_reg <= START_DUTY_RESET;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr == ADDR_CTRL) begin
        run_enable <= pwdata[CTRL_RUN_BIT];
        brake_enable <= pwdata[CTRL_BRAKE_BIT];
        auto_restart_enable <= pwdata[CTRL_RESTART_BIT];
        serial_sel <= pwdata[CTRL_SERIAL_BIT];
      end else if (paddr == ADDR_CFG) begin
        max_speed_select <= pwdata[CFG_SMX_LSB +: 3];
        bridge_period_select <= pwdata[CFG_PERIOD_LSB +: 5];
        prop_gain_select <= pwdata[CFG_PGAIN_LSB +: 3];
        integ_gain_select <= pwdata[CFG_IGAIN_LSB +: 3];
      end else if (paddr == ADDR_DEMAND) begin
        serial_duty_reg <= pwdata[7:0];
      end else if (paddr == ADDR_START) begin
        start_speed_reg <= pwdata[START_SPEED_LSB +: 16];
        start_duty_reg <= pwdata[START_DUTY_LSB +: 8];
      end
    end
  end
endmodule

//--- testbench/closed_loop_speed_control_test.sv
/*
  self-checking bench for the closed-loop speed controller.
  assumes the design and its bound checker; inputs change on rising edges.
*/
`define CHK(name, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("mismatch %s expected %h seen %h", name, exp, got); \
    end \
  end
`define WAIT_FOR(cond, lim) \
  begin \
    n = 0; \
    while (!(cond) && n < (lim)) begin \
      @(negedge pclk); \
      n++; \
    end \
  end
module closed_loop_speed_control_test import clsc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PERIOD = 200;
  localparam int GATE = 200;
  typedef struct {
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic slverr;
  } clsc_row_t;
  clsc_row_t rows [9] = '{
    '{1'b0, ADDR_CTRL, 32'h0000_0000, 32'h0000_0003, 1'b0},
    '{1'b0, ADDR_CFG, 32'h0000_0000, 32'h0023_1307, 1'b0},
    '{1'b0, ADDR_DEMAND, 32'h0000_0000, 32'h0000_0000, 1'b0},
    '{1'b0, ADDR_START, 32'h0000_0000, 32'h0040_0064, 1'b0},
    '{1'b1, ADDR_CFG, 32'h0012_0A05, 32'h0000_0000, 1'b0},
    '{1'b0, ADDR_CFG, 32'h0000_0000, 32'h0012_0A05, 1'b0},
    '{1'b1, ADDR_STATUS, 32'h0000_00FF, 32'h0000_0000, 1'b0},
    '{1'b0, 8'h1C, 32'h0000_0000, 32'h0000_0000, 1'b1},
    '{1'b1, 8'h18, 32'h0000_0001, 32'h0000_0000, 1'b1}};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pwm_in, current_limit_in;
  logic comm_tick, hold_done, sync_lost, bridge_pwm, bridge_enable, brake_out, start_req;
  logic fault_out_n, src_on, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] src_high;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;
  clsc_speed_ctrl #(.GATE_CYCLES(GATE)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pwm_in(pwm_in), .current_limit_in(current_limit_in),
    .comm_tick(comm_tick), .hold_done(hold_done), .sync_lost(sync_lost),
    .bridge_pwm(bridge_pwm), .bridge_enable(bridge_enable), .brake_out(brake_out),
    .start_req(start_req), .fault_out_n(fault_out_n));
  clsc_pwm_source src (.pclk(pclk), .presetn(presetn), .active(src_on),
    .period(16'(PERIOD)), .high_cycles(src_high), .pwm_out(pwm_in));
  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ready and read data are taken at the rising edge that completes the access
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] data, output logic slverr);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    data = prdata;
    slverr = pslverr;
    `CHK("pready", 1'b1, pready)
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      report_and_stop();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, current_limit_in, comm_tick} = 6'b00_0000;
    {hold_done, sync_lost, src_on} = 3'b000;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    src_high = 16'h0000;
    repeat (20) @(posedge pclk);
    `CHK("fault_out_n", 1'b1, fault_out_n)
    `CHK("brake_out", 1'b0, brake_out)
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].addr, rows[i].wdata, rd, err);
      `CHK("prdata", rows[i].rdata, rd)
      `CHK("pslverr", rows[i].slverr, err)
    end
    `CHK("brake_out", 1'b1, brake_out)
    // 20 percent sits between the brake and start thresholds
    @(posedge pclk);
    src_high <= 16'd40;
    src_on <= 1'b1;
    repeat (5 * PERIOD) @(negedge pclk);
    `CHK("brake_out", 1'b0, brake_out)
    `CHK("bridge_enable", 1'b0, bridge_enable)
    @(posedge pclk);
    src_high <= 16'd100;
    `WAIT_FOR(start_req === 1'b1, 4 * PERIOD)
    `CHK("start_req", 1'b1, start_req)
    @(negedge pclk);
    `CHK("bridge_enable", 1'b1, bridge_enable)
    @(posedge pclk);
    src_on <= 1'b0;
    `WAIT_FOR(brake_out === 1'b1, 6 * PERIOD)
    `CHK("brake delay", 1'b1, n > 2 * PERIOD - 10 && n < 2 * PERIOD + 20)
    `CHK("bridge_enable", 1'b0, bridge_enable)
    apb(1'b1, ADDR_CTRL, 32'h0000_0007, rd, err);
    @(posedge pclk);
    src_on <= 1'b1;
    hold_done <= 1'b1;
    `WAIT_FOR(start_req === 1'b1, 6 * PERIOD)
    `CHK("start_req", 1'b1, start_req)
    repeat (2) begin
      @(posedge pclk);
      comm_tick <= 1'b1;
      @(posedge pclk);
      comm_tick <= 1'b0;
    end
    // let the loop reach full duty so the bridge is on at the trip edge
    repeat (2 * GATE) @(negedge pclk);
    `WAIT_FOR(bridge_pwm === 1'b1, 20 * GATE)
    `CHK("bridge_pwm", 1'b1, bridge_pwm)
    @(posedge pclk);
    current_limit_in <= 1'b1;
    @(posedge pclk);
    current_limit_in <= 1'b0;
    repeat (100) @(negedge pclk);
    `CHK("bridge_pwm", 1'b0, bridge_pwm)
    @(posedge pclk);
    sync_lost <= 1'b1;
    `WAIT_FOR(fault_out_n === 1'b0, 4 * PERIOD)
    @(posedge pclk);
    sync_lost <= 1'b0;
    `CHK("fault_out_n", 1'b0, fault_out_n)
    `CHK("bridge_enable", 1'b0, bridge_enable)
    `WAIT_FOR(fault_out_n === 1'b1, 6 * PERIOD)
    `CHK("fault low time", 1'b1, n > 2 * PERIOD - 10 && n < 3 * PERIOD + 20)
    `WAIT_FOR(start_req === 1'b1, 12 * PERIOD)
    `CHK("restart", 1'b1, start_req)
    apb(1'b1, ADDR_CTRL, 32'h0000_0001, rd, err);
    @(posedge pclk);
    src_on <= 1'b0;
    repeat (8 * PERIOD) @(negedge pclk);
    `CHK("brake_out", 1'b0, brake_out)
    `CHK("bridge_enable", 1'b0, bridge_enable)
    apb(1'b1, ADDR_CTRL, 32'h0000_0009, rd, err);
    apb(1'b1, ADDR_DEMAND, 32'h0000_0080, rd, err);
    `WAIT_FOR(start_req === 1'b1, 4 * GATE)
    `CHK("serial start", 1'b1, start_req)
    report_and_stop();
  end
endmodule

//--- testbench/clsc_pwm_source.sv
/*
  behavioural duty-cycle source in place of the external controller.
  assumes the bench changes period and high count only by non-blocking assignment.
*/
module clsc_pwm_source (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic active,
  input wire logic [15:0] period,
  input wire logic [15:0] high_cycles,
  output logic pwm_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] count_reg;
  // period scaled far below the legal range to keep runs short, but held stable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 16'h0000;
      pwm_out <= 1'b0;
    end else if (!active) begin
      count_reg <= 16'h0000;
      pwm_out <= 1'b0;
    end else begin
      count_reg <= (count_reg + 16'h0001 >= period) ? 16'h0000 : count_reg + 16'h0001;
      pwm_out <= count_reg < high_cycles;
    end
  end
endmodule

//--- testbench/clsc_speed_ctrl_assertions.sv
/*
  port checker for the closed-loop speed controller.
  assumes it is bound to clsc_speed_ctrl and sees only that module's ports.
*/
module clsc_speed_ctrl_chk
  import clsc_pkg::*;
#(
  parameter int GATE_CYCLES = SPEED_GATE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pwm_in,
  input wire logic current_limit_in,
  input wire logic comm_tick,
  input wire logic hold_done,
  input wire logic sync_lost,
  input wire logic bridge_pwm,
  input wire logic bridge_enable,
  input wire logic brake_out,
  input wire logic start_req,
  input wire logic fault_out_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic brk_reg;
  logic unmapped;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign unmapped = !(paddr inside {ADDR_CTRL, ADDR_CFG, ADDR_DEMAND, ADDR_START,
    ADDR_STATUS, ADDR_SPEED});
  // shadow of the brake bit, taken from completed control writes only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brk_reg <= CTRL_RESET[CTRL_BRAKE_BIT];
    end else if (psel && penable && pready && pwrite && paddr == ADDR_CTRL) begin
      brk_reg <= pwdata[CTRL_BRAKE_BIT];
    end
  end
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_trip;
    current_limit_in && bridge_pwm;
  endsequence
  ready_timing_a: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  read_zero_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside access");
  slverr_map_a: assert property (pready |-> pslverr == unmapped)
    else $error("error flag does not match address map");
  brake_gate_a: assert property (brake_out |-> $past(brk_reg))
    else $error("brake with brake enable clear");
  brake_bridge_a: assert property (brake_out |-> !bridge_enable)
    else $error("bridge enabled while braking");
  trip_off_a: assert property (s_trip |-> ##[1:2] (!bridge_pwm [*8]))
    else $error("bridge not held off after current trip");
  start_pulse_a: assert property (start_req |=>
    bridge_enable && (!start_req || $past(sync_lost)))
    else $error("start request not a single pulse with bridge on");
  fault_bridge_a: assert property ($fell(fault_out_n) |-> ##[0:2] !bridge_enable)
    else $error("bridge still on at loss of sync");
  fault_hold_a: assert property ($fell(fault_out_n) |=> !fault_out_n [*8])
    else $error("fault low phase too short");
endmodule
bind clsc_speed_ctrl clsc_speed_ctrl_chk #(.GATE_CYCLES(GATE_CYCLES)) chk (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .pwm_in,
  .current_limit_in, .comm_tick, .hold_done, .sync_lost, .bridge_pwm, .bridge_enable,
  .brake_out, .start_req, .fault_out_n);
